/* File: ppa_page_map.sv */
`timescale 1ns/1ps
module ppa_page_map
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// decoded command transactions
	input wire ppa_pkg::ppa_req_s req,
	output ppa_pkg::ppa_rsp_s rsp,
	// address match
	input wire logic [6:0] busAddr,
	output logic addrHit,
	// pins: select level 0 low, 1 mid, 2 high
	input wire logic [1:0] addrSelLowPin,
	input wire logic [1:0] addrSelHighPin,
	input wire logic wpPin,
	// global-capable command fan-out
	output logic [3:0] chanCmdStrobe,
	output logic [7:0] chanCmdCode,
	output logic [15:0] chanCmdData,
	// fault log
	input wire ppa_pkg::ppa_flog_s flogWr,
	input wire logic flogLockSet,
	output logic flogClrPulse,
	// telemetry and status
	input wire ppa_pkg::ppa_meas_s meas,
	input wire logic [7:0] commonStatus,
	// configuration
	output logic [7:0] retryLimit
);
	import ppa_pkg::*;

	function automatic logic isPaged(input logic [7:0] c);
		isPaged = (c == CMD_OPERATION) || (c == CMD_ON_OFF_CONFIG) || (c == CMD_CLEAR_FAULTS)
			|| (c == CMD_GAIN_TC) || (c == CMD_DIODE_GAIN) || (c == CMD_TEMP_OFFSET)
			|| (c == CMD_SENSE_V) || (c == CMD_VOUT_MIN) || (c == CMD_TEMP_MIN);
	endfunction : isPaged

	function automatic logic isGlobal(input logic [7:0] c);
		isGlobal = (c == CMD_CLEAR_FAULTS) || (c == CMD_OPERATION) || (c == CMD_ON_OFF_CONFIG);
	endfunction : isGlobal

	function automatic logic wpAllows(input ppa_wpl_e lvl, input logic [7:0] c);
		logic base;
		logic ctl;
		base = (c == CMD_WRITE_PROTECT) || (c == CMD_PAGE) || (c == CMD_NV_UNLOCK)
			|| (c == CMD_STORE_USER_ALL);
		ctl = (c == CMD_OPERATION) || (c == CMD_ALT_CMD) || (c == CMD_CHAN_MASK)
			|| (c == CMD_CLEAR_ENERGY) || (c == CMD_CLEAR_FAULTS);
		case (lvl)
			WPL_L1: wpAllows = base;
			WPL_L2: wpAllows = base || ctl;
			default: wpAllows = 1'b1;
		endcase
	endfunction : wpAllows

	// scaled by 2^16 so every exponent -16..15 lands on an integer
	function automatic logic signed [47:0] linearFix(input logic [15:0] w);
		logic [5:0] sh;
		logic signed [47:0] m;
		sh = {w[LINEAR_EXP_MSB], w[LINEAR_EXP_MSB:LINEAR_EXP_LSB]} + 6'h10;
		m = {{37{w[LINEAR_MAN_MSB]}}, w[LINEAR_MAN_MSB:0]};
		linearFix = m <<< sh;
	endfunction : linearFix

	function automatic logic [3:0] selOffset(input logic [1:0] hi, input logic [1:0] lo);
		logic [3:0] h;
		logic [3:0] l;
		h = (hi > 2'h2) ? 4'h2 : {2'h0, hi};
		l = (lo > 2'h2) ? 4'h2 : {2'h0, lo};
		selOffset = 4'((h << 1) + h + l);
	endfunction : selOffset

	logic [1:0] aselLoMeta_r, aselLo_r, aselHiMeta_r, aselHi_r;
	logic wpMeta_r, wpSync_r;
	logic [7:0] page_r, wpReg_r, retry_r;
	logic [3:0] chanMask_r;
	logic [6:0] baseAddr_r;
	logic [15:0] altCmd_r, altData0_r, altData1_r;
	logic [15:0] gainTc_r [NUM_CHAN];
	logic [15:0] diodeGain_r [NUM_CHAN];
	logic [15:0] tempOffset_r [NUM_CHAN];
	logic [15:0] sense_r [NUM_CHAN];
	logic [15:0] voutMin_r [NUM_CHAN];
	logic [15:0] tempMin_r [NUM_CHAN];
	logic [15:0] vinMin_r;
	logic [NUM_CHAN-1:0] chanSeen_r;
	logic vinSeen_r;
	logic [7:0] flogMem [FLOG_BYTES];
	logic flogLock_r, clrBusy_r;
	logic [3:0] clrIdx_r;
	logic [4:0] blkPtr_r;
	ppa_wpl_e wpLevel;
	logic pageFF, pageOk, paged, wr, rd, wrGo, cmlNow;
	logic [1:0] ch;
	logic [15:0] rdData;
	logic known;
	logic [3:0] gpTargets;

	// pins cross into this clock through two flops
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			aselLoMeta_r <= 2'h0;
			aselLo_r <= 2'h0;
			aselHiMeta_r <= 2'h0;
			aselHi_r <= 2'h0;
			wpMeta_r <= 1'b0;
			wpSync_r <= 1'b0;
		end
		else
		begin
			aselLoMeta_r <= addrSelLowPin;
			aselLo_r <= aselLoMeta_r;
			aselHiMeta_r <= addrSelHighPin;
			aselHi_r <= aselHiMeta_r;
			wpMeta_r <= wpPin;
			wpSync_r <= wpMeta_r;
		end
	end

	assign addrHit = (busAddr == 7'(baseAddr_r + {3'h0, selOffset(aselHi_r, aselLo_r)}));

	// most restrictive of pin and register wins
	always_comb
	begin
		if (wpReg_r == WP_LEVEL1)
			wpLevel = WPL_L1;
		else if (wpReg_r == WP_LEVEL2 || wpSync_r)
			wpLevel = WPL_L2;
		else
			wpLevel = WPL_NONE;
	end

	assign pageFF = (page_r == PAGE_GLOBAL);
	assign pageOk = (page_r <= PAGE_LAST);
	assign ch = page_r[1:0];
	assign paged = isPaged(req.code);
	assign wr = req.valid && req.write;
	assign rd = req.valid && !req.write;
	// non-paged commands never look at the page
	assign wrGo = wr && wpAllows(wpLevel, req.code)
		&& (!paged || pageOk || (pageFF && isGlobal(req.code)));
	assign cmlNow = paged && pageFF && (rd || (wr && !isGlobal(req.code)));
	assign gpTargets = pageFF ? chanMask_r : (4'h1 << ch);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			page_r <= RST_PAGE;
			wpReg_r <= RST_WP;
			chanMask_r <= RST_CHAN_MASK;
			baseAddr_r <= RST_BASE_ADDR;
			retry_r <= RST_RETRY;
			altCmd_r <= RST_ZERO;
			altData0_r <= RST_ZERO;
			altData1_r <= RST_ZERO;
		end
		else if (wrGo && !req.sendByte)
		begin
			case (req.code)
				CMD_PAGE: page_r <= req.data[7:0];
				CMD_WRITE_PROTECT: wpReg_r <= req.data[7:0];
				CMD_CHAN_MASK: chanMask_r <= req.data[3:0];
				CMD_BASE_ADDR: baseAddr_r <= req.data[6:0];
				CMD_RETRY: retry_r <= req.data[7:0];
				CMD_ALT_CMD: altCmd_r <= req.data;
				CMD_ALT_DATA0: altData0_r <= req.data;
				CMD_ALT_DATA1: altData1_r <= req.data;
				default: ;
			endcase
		end
	end

	assign retryLimit = retry_r;

	// paged calibration words; global page never reaches these
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_CHAN; i++)
			begin
				gainTc_r[i] <= RST_GAIN_TC;
				diodeGain_r[i] <= RST_DIODE_GAIN;
				tempOffset_r[i] <= RST_TEMP_OFFSET;
			end
		end
		else if (wrGo && pageOk && !req.sendByte)
		begin
			case (req.code)
				CMD_GAIN_TC: gainTc_r[ch] <= req.data;
				CMD_DIODE_GAIN: diodeGain_r[ch] <= req.data;
				CMD_TEMP_OFFSET: tempOffset_r[ch] <= req.data;
				default: ;
			endcase
		end
	end

	// fan-out of clear-faults, operation and on-off-config
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			chanCmdStrobe <= 4'h0;
			chanCmdCode <= 8'h00;
			chanCmdData <= RST_ZERO;
		end
		else
		begin
			chanCmdStrobe <= (wrGo && isGlobal(req.code)) ? gpTargets : 4'h0;
			if (wrGo && isGlobal(req.code))
			begin
				chanCmdCode <= req.code;
				chanCmdData <= req.data;
			end
		end
	end

	// minimum trackers; first sample after reset always loads
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_CHAN; i++)
			begin
				sense_r[i] <= RST_ZERO;
				voutMin_r[i] <= RST_ZERO;
				tempMin_r[i] <= RST_ZERO;
			end
			vinMin_r <= RST_ZERO;
			chanSeen_r <= 4'h0;
			vinSeen_r <= 1'b0;
		end
		else if (meas.valid)
		begin
			sense_r[meas.chan] <= meas.sense;
			chanSeen_r[meas.chan] <= 1'b1;
			vinSeen_r <= 1'b1;
			if (!chanSeen_r[meas.chan] || meas.vout < voutMin_r[meas.chan])
				voutMin_r[meas.chan] <= meas.vout;
			if (!chanSeen_r[meas.chan] || linearFix(meas.temp) < linearFix(tempMin_r[meas.chan]))
				tempMin_r[meas.chan] <= meas.temp;
			if (!vinSeen_r || linearFix(meas.vin) < linearFix(vinMin_r))
				vinMin_r <= meas.vin;
		end
	end

	// log storage is wiped at reset and on clear, one byte a cycle
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			clrBusy_r <= 1'b1;
			clrIdx_r <= 4'h0;
			flogLock_r <= 1'b0;
			flogClrPulse <= 1'b0;
		end
		else
		begin
			flogClrPulse <= wrGo && req.sendByte && (req.code == CMD_FLOG_CLEAR);
			if (wrGo && req.sendByte && (req.code == CMD_FLOG_CLEAR))
			begin
				clrBusy_r <= 1'b1;
				clrIdx_r <= 4'h0;
			end
			else if (clrBusy_r)
			begin
				clrIdx_r <= clrIdx_r + 4'h1;
				clrBusy_r <= (clrIdx_r != 4'(FLOG_BYTES - 1));
			end
			// a lock event in the clearing cycle still sets the lock
			if (flogLockSet)
				flogLock_r <= 1'b1;
			else if (wrGo && req.sendByte && (req.code == CMD_FLOG_CLEAR))
				flogLock_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (clrBusy_r)
			flogMem[clrIdx_r] <= 8'h00;
		else if (flogWr.valid)
			flogMem[flogWr.addr] <= flogWr.data;
	end

	// block pointer: 0 gives the count, then the bytes; any other command restarts it
	always_ff @(posedge clk)
	begin
		if (!nrst)
			blkPtr_r <= 5'h00;
		else if (rd && req.code == CMD_FLOG_DATA)
			blkPtr_r <= (blkPtr_r == 5'(FLOG_BYTES)) ? 5'h00 : blkPtr_r + 5'h01;
		else if (req.valid)
			blkPtr_r <= 5'h00;
	end

	always_comb
	begin
		rdData = RST_ZERO;
		known = 1'b1;
		case (req.code)
			CMD_PAGE: rdData = {8'h00, page_r};
			CMD_WRITE_PROTECT: rdData = {8'h00, wpReg_r};
			CMD_CHAN_MASK: rdData = {12'h000, chanMask_r};
			CMD_BASE_ADDR: rdData = {9'h000, baseAddr_r};
			CMD_ALT_CMD: rdData = altCmd_r;
			CMD_ALT_DATA0: rdData = altData0_r;
			CMD_ALT_DATA1: rdData = altData1_r;
			CMD_RETRY: rdData = {8'h00, retry_r};
			CMD_COMMON: rdData = {8'h00, commonStatus};
			CMD_VIN_MIN: rdData = vinMin_r;
			CMD_FLOG_STATUS:
			begin
				rdData[FLOG_LOCK_BIT] = flogLock_r;
				rdData[FLOG_BUSY_BIT] = clrBusy_r;
			end
			CMD_FLOG_DATA:
			begin
				if (blkPtr_r == 5'h00)
					rdData = 16'(FLOG_BYTES);
				else
					rdData = {8'h00, flogMem[4'(blkPtr_r - 5'h01)]};
			end
			CMD_GAIN_TC: rdData = gainTc_r[ch];
			CMD_DIODE_GAIN: rdData = diodeGain_r[ch];
			CMD_TEMP_OFFSET: rdData = tempOffset_r[ch];
			CMD_SENSE_V: rdData = sense_r[ch];
			CMD_VOUT_MIN: rdData = voutMin_r[ch];
			CMD_TEMP_MIN: rdData = tempMin_r[ch];
			default: known = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			rsp <= '0;
		else
		begin
			rsp.valid <= req.valid;
			rsp.known <= req.valid && known;
			rsp.cml <= req.valid && cmlNow;
			rsp.data <= rd ? rdData : RST_ZERO;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence flogClrCmd;
		wrGo && req.sendByte && (req.code == CMD_FLOG_CLEAR) && !flogLockSet;
	endsequence
	sequence flogWipe;
		clrBusy_r [*8] ##1 clrBusy_r [*8] ##1 !clrBusy_r;
	endsequence

	page_reset_a: assert property ($rose(nrst) |-> page_r == RST_PAGE && retry_r == RST_RETRY)
		else $error("page or retry not at reset value");
	global_mask_a: assert property (wr && pageFF && isGlobal(req.code) && wpLevel == WPL_NONE
		|=> chanCmdStrobe == $past(chanMask_r))
		else $error("global write did not follow channel mask");
	global_only_a: assert property (wr && pageFF && !isGlobal(req.code) && paged
		|=> rsp.cml && chanCmdStrobe == 4'h0)
		else $error("non-global write at page ff not rejected");
	paged_read_a: assert property (rd && pageFF && paged |=> rsp.valid && rsp.cml)
		else $error("paged read at page ff without fault");
	nonpaged_read_a: assert property (rd && pageFF && !paged |=> !rsp.cml)
		else $error("non-paged read faulted at page ff");
	chan_route_a: assert property (wr && !req.sendByte && req.code == CMD_DIODE_GAIN && pageOk
		&& wpLevel == WPL_NONE |=> diodeGain_r[$past(ch)] == $past(req.data))
		else $error("paged write missed the selected channel");
	level1_block_a: assert property (wr && wpLevel == WPL_L1 && req.code == CMD_CHAN_MASK
		|=> $stable(chanMask_r))
		else $error("mask changed under level 1 protection");
	flog_clear_a: assert property (flogClrCmd |=> !flogLock_r ##0 flogWipe)
		else $error("fault log clear did not release lock and wipe");
	sense_ro_a: assert property (wr && req.code == CMD_SENSE_V && !meas.valid
		|=> $stable(sense_r[0]) && $stable(sense_r[1])
		&& $stable(sense_r[2]) && $stable(sense_r[3]))
		else $error("read-only sense word changed on write");
endmodule : ppa_page_map

/* File: ppa_pkg.sv */
// Functional notes
// - page values 0..3 steer every paged command to channel 0..3
// - page 0xFF writes all pages only for clear-faults, operation, on-off-config
// - global-page writes reach only channels enabled in the channel mask
// - paged reads at page 0xFF return undefined data and raise a CML fault
// - non-global paged writes at page 0xFF are dropped and raise a CML fault
// - 5s/11s linear word: 5-bit signed exponent over 11-bit signed mantissa
// - 16-bit unsigned linear word with fixed, non-programmable exponent -13
// - page selector is a non-paged, volatile read/write byte resetting to 0x00
// - write-protect level at 0x10 is a non-paged stored byte, default 0x00
// - channel mask at 0xE4 is a non-paged stored byte, default 0x0F
// - words 0xC8..0xCA: shared alt-host command, alt-host 0 and 1 data
// - send-byte 0xEC initialises fault-log storage and releases the log lock
// - 0xEE is a block read returning fault-log bytes in sequence
// - 0xED is a non-paged read-only fault-logging status byte
// - retry count at 0xF7 shared by all retrying faults, default 0x07
// - paged diode gain word, 2^-14 per step, default 0x4000 meaning one
// - paged temperature offset word in 5s/11s format, default 0x8000
// - paged read-only sense voltage magnitude, 3.05 microvolts per step
// - read-only minimum trackers for vout, vin and temperature at 0xFB..0xFD
// - paged current-gain tempco word at 0xF6, read/write, default 0x0000
// - protect 0x80 allows few writes; 0x40 also allows control writes
// - device answers at base address plus pin-selected offset 0..8
package ppa_pkg;
	localparam int NUM_CHAN = 4;
	localparam int FLOG_BYTES = 16;
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
	localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
	localparam logic [7:0] CMD_ALT_CMD = 8'hc8;
	localparam logic [7:0] CMD_ALT_DATA0 = 8'hc9;
	localparam logic [7:0] CMD_ALT_DATA1 = 8'hca;
	localparam logic [7:0] CMD_CLEAR_ENERGY = 8'hcc;
	localparam logic [7:0] CMD_NV_UNLOCK = 8'hbd;
	localparam logic [7:0] CMD_CHAN_MASK = 8'he4;
	localparam logic [7:0] CMD_BASE_ADDR = 8'he6;
	localparam logic [7:0] CMD_FLOG_CLEAR = 8'hec;
	localparam logic [7:0] CMD_FLOG_STATUS = 8'hed;
	localparam logic [7:0] CMD_FLOG_DATA = 8'hee;
	localparam logic [7:0] CMD_COMMON = 8'hef;
	localparam logic [7:0] CMD_GAIN_TC = 8'hf6;
	localparam logic [7:0] CMD_RETRY = 8'hf7;
	localparam logic [7:0] CMD_DIODE_GAIN = 8'hf8;
	localparam logic [7:0] CMD_TEMP_OFFSET = 8'hf9;
	localparam logic [7:0] CMD_SENSE_V = 8'hfa;
	localparam logic [7:0] CMD_VOUT_MIN = 8'hfb;
	localparam logic [7:0] CMD_VIN_MIN = 8'hfc;
	localparam logic [7:0] CMD_TEMP_MIN = 8'hfd;
	localparam logic [7:0] PAGE_GLOBAL = 8'hff;
	localparam logic [7:0] PAGE_LAST = 8'h03;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_WP = 8'h00;
	localparam logic [7:0] WP_LEVEL1 = 8'h80;
	localparam logic [7:0] WP_LEVEL2 = 8'h40;
	localparam logic [3:0] RST_CHAN_MASK = 4'hf;
	localparam logic [6:0] RST_BASE_ADDR = 7'h5c;
	localparam logic [7:0] RST_RETRY = 8'h07;
	localparam logic [15:0] RST_GAIN_TC = 16'h0000;
	localparam logic [15:0] RST_DIODE_GAIN = 16'h4000;
	localparam logic [15:0] RST_TEMP_OFFSET = 16'h8000;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam int LINEAR_EXP_MSB = 15;
	localparam int LINEAR_EXP_LSB = 11;
	localparam int LINEAR_MAN_MSB = 10;
	localparam int LINEAR16_EXP = -13;
	localparam int FLOG_LOCK_BIT = 0;
	localparam int FLOG_BUSY_BIT = 1;

	typedef enum logic [1:0]
	{
		WPL_NONE = 2'b00,
		WPL_L2 = 2'b01,
		WPL_L1 = 2'b10
	} ppa_wpl_e;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic sendByte;
		logic [7:0] code;
		logic [15:0] data;
	} ppa_req_s;

	typedef struct packed
	{
		logic valid;
		logic known;
		logic cml;
		logic [15:0] data;
	} ppa_rsp_s;

	typedef struct packed
	{
		logic valid;
		logic [1:0] chan;
		logic [15:0] vout;
		logic [15:0] temp;
		logic [15:0] sense;
		logic [15:0] vin;
	} ppa_meas_s;

	typedef struct packed
	{
		logic valid;
		logic [3:0] addr;
		logic [7:0] data;
	} ppa_flog_s;
endpackage : ppa_pkg

/* File: ppa_host_model.sv */
`timescale 1ns/1ps
module ppa_host_model
import ppa_pkg::*;
(
	// clock
	input wire logic clk,
	// command port
	output ppa_pkg::ppa_req_s req,
	input wire ppa_pkg::ppa_rsp_s rsp
);
	initial req = '0;

	// callers only send page values 0..3 or the global value
	// request is held through its taking edge; the answer is registered on that same edge and read 1ns after it
	task automatic xfer(input logic w, input logic sb, input logic [7:0] code,
		input logic [15:0] data, output ppa_rsp_s r);
		@(posedge clk);
		#1;
		req = '{1'b1, w, sb, code, data};
		@(posedge clk);
		#1;
		req = '0;
		r = rsp;
	endtask : xfer
endmodule : ppa_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import ppa_pkg::*;
	logic clk, nrst, addrHit, wpPin, flogLockSet, flogClrPulse;
	logic [6:0] busAddr;
	logic [1:0] selLo, selHi;
	logic [3:0] chanCmdStrobe;
	logic [7:0] chanCmdCode, commonStatus, retryLimit;
	logic [15:0] chanCmdData;
	ppa_req_s req;
	ppa_rsp_s rsp, r;
	ppa_meas_s meas;
	ppa_flog_s flogWr;
	int num_errors, n_compared, cycles;

	ppa_page_map i_dut (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .busAddr(busAddr),
		.addrHit(addrHit), .addrSelLowPin(selLo), .addrSelHighPin(selHi), .wpPin(wpPin),
		.chanCmdStrobe(chanCmdStrobe), .chanCmdCode(chanCmdCode), .chanCmdData(chanCmdData),
		.flogWr(flogWr), .flogLockSet(flogLockSet), .flogClrPulse(flogClrPulse),
		.meas(meas), .commonStatus(commonStatus), .retryLimit(retryLimit));
	ppa_host_model i_host (.clk(clk), .req(req), .rsp(rsp));

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		i_host.xfer(1'b1, 1'b0, code, data, r);
	endtask : wr

	// valid, no fault, known code, expected data
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		i_host.xfer(1'b0, 1'b0, code, 16'h0000, r);
		check({r.valid, r.cml, r.known, 1'b0, r.data}, {4'ha, exp});
	endtask : rd

	task automatic t_reset;
		logic [7:0] zeroCodes [7] = '{CMD_ALT_CMD, CMD_ALT_DATA0, CMD_ALT_DATA1, CMD_SENSE_V,
			CMD_VOUT_MIN, CMD_VIN_MIN, CMD_TEMP_MIN};
		rd(CMD_PAGE, 16'h0000);
		rd(CMD_WRITE_PROTECT, 16'h0000);
		rd(CMD_CHAN_MASK, 16'h000f);
		rd(CMD_BASE_ADDR, 16'h005c);
		rd(CMD_RETRY, 16'h0007);
		check(20'(retryLimit), 20'h00007);
		rd(CMD_GAIN_TC, 16'h0000);
		rd(CMD_DIODE_GAIN, 16'h4000);
		rd(CMD_TEMP_OFFSET, 16'h8000);
		foreach (zeroCodes[i])
			rd(zeroCodes[i], 16'h0000);
	endtask : t_reset

	task automatic t_paging;
		for (int p = 0; p < 4; p++)
		begin
			wr(CMD_PAGE, 16'(p));
			wr(CMD_DIODE_GAIN, 16'h1000 + 16'(p));
			wr(CMD_GAIN_TC, 16'h0100 + 16'(p));
			wr(CMD_TEMP_OFFSET, 16'hd280 + 16'(p));
		end
		for (int p = 0; p < 4; p++)
		begin
			wr(CMD_PAGE, 16'(p));
			rd(CMD_PAGE, 16'(p));
			rd(CMD_DIODE_GAIN, 16'h1000 + 16'(p));
			rd(CMD_GAIN_TC, 16'h0100 + 16'(p));
			rd(CMD_TEMP_OFFSET, 16'hd280 + 16'(p));
		end
	endtask : t_paging

	task automatic t_global;
		logic [7:0] gCodes [3] = '{CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_CLEAR_FAULTS};
		wr(CMD_OPERATION, 16'h0040);
		check(20'(chanCmdStrobe), 20'h00008);
		wr(CMD_CHAN_MASK, 16'h0005);
		wr(CMD_PAGE, 16'(PAGE_GLOBAL));
		foreach (gCodes[i])
		begin
			i_host.xfer(1'b1, gCodes[i] == CMD_CLEAR_FAULTS, gCodes[i], 16'h0080, r);
			check({r.cml, chanCmdStrobe, chanCmdCode}, {7'h05, gCodes[i]});
		end
		check(20'(chanCmdData), 20'h00080);
		i_host.xfer(1'b0, 1'b0, CMD_DIODE_GAIN, 16'h0000, r);
		check(20'(r.cml), 20'h00001);
		i_host.xfer(1'b0, 1'b0, CMD_OPERATION, 16'h0000, r);
		check({r.valid, r.known, r.cml}, 3'b101);
		i_host.xfer(1'b1, 1'b0, CMD_DIODE_GAIN, 16'h7777, r);
		check({r.cml, chanCmdStrobe}, 20'h00010);
		rd(CMD_RETRY, 16'h0007);
		wr(CMD_PAGE, 16'h0000);
		rd(CMD_DIODE_GAIN, 16'h1000);
	endtask : t_global

	task automatic t_protect;
		wr(CMD_WRITE_PROTECT, 16'(WP_LEVEL1));
		wr(CMD_RETRY, 16'h0003);
		wr(CMD_CHAN_MASK, 16'h0003);
		wr(CMD_PAGE, 16'h0001);
		rd(CMD_RETRY, 16'h0007);
		rd(CMD_CHAN_MASK, 16'h0005);
		rd(CMD_PAGE, 16'h0001);
		wr(CMD_WRITE_PROTECT, 16'(WP_LEVEL2));
		wr(CMD_CHAN_MASK, 16'h0003);
		wr(CMD_RETRY, 16'h0003);
		rd(CMD_CHAN_MASK, 16'h0003);
		rd(CMD_RETRY, 16'h0007);
		wr(CMD_WRITE_PROTECT, 16'h0000);
		wpPin = 1'b1;
		repeat (3) @(posedge clk);
		wr(CMD_RETRY, 16'h0003);
		rd(CMD_RETRY, 16'h0007);
		wpPin = 1'b0;
		repeat (3) @(posedge clk);
		wr(CMD_RETRY, 16'h0002);
		rd(CMD_RETRY, 16'h0002);
		check(20'(retryLimit), 20'h00002);
	endtask : t_protect

	task automatic t_flog;
		@(posedge clk);
		#1 flogWr = '{1'b1, 4'h0, 8'ha5};
		@(posedge clk);
		#1 flogWr = '{1'b1, 4'hf, 8'h3c};
		@(posedge clk);
		#1 flogWr = '0;
		flogLockSet = 1'b1;
		@(posedge clk);
		#1 flogLockSet = 1'b0;
		rd(CMD_FLOG_STATUS, 16'h0001);
		wr(CMD_FLOG_STATUS, 16'h0000);
		rd(CMD_FLOG_STATUS, 16'h0001);
		rd(CMD_FLOG_DATA, 16'(FLOG_BYTES));
		rd(CMD_FLOG_DATA, 16'h00a5);
		repeat (14) i_host.xfer(1'b0, 1'b0, CMD_FLOG_DATA, 16'h0000, r);
		rd(CMD_FLOG_DATA, 16'h003c);
		rd(CMD_FLOG_DATA, 16'(FLOG_BYTES));
		i_host.xfer(1'b1, 1'b1, CMD_FLOG_CLEAR, 16'h0000, r);
		check(20'(flogClrPulse), 20'h00001);
		rd(CMD_FLOG_STATUS, 16'h0002);
		repeat (16) @(posedge clk);
		rd(CMD_FLOG_STATUS, 16'h0000);
		rd(CMD_FLOG_DATA, 16'(FLOG_BYTES));
		rd(CMD_FLOG_DATA, 16'h0000);
		// a lock event in the clearing cycle must win
		flogLockSet = 1'b1;
		i_host.xfer(1'b1, 1'b1, CMD_FLOG_CLEAR, 16'h0000, r);
		flogLockSet = 1'b0;
		rd(CMD_FLOG_STATUS, 16'h0003);
	endtask : t_flog

	task automatic sample(input logic [15:0] v, input logic [15:0] t, input logic [15:0] s);
		@(posedge clk);
		#1 meas = '{1'b1, 2'h1, v, t, s, t};
		@(posedge clk);
		#1 meas.valid = 1'b0;
	endtask : sample

	// second temp and vin samples are lower in value but not in plain signed/unsigned bit order; vout is lower in plain unsigned order
	task automatic t_meas;
		sample(16'h9800, 16'hd280, 16'h0123);
		sample(16'h1000, 16'hf801, 16'h0456);
		sample(16'h2000, 16'hd280, 16'h0456);
		wr(CMD_PAGE, 16'h0001);
		rd(CMD_VOUT_MIN, 16'h1000);
		rd(CMD_TEMP_MIN, 16'hf801);
		rd(CMD_VIN_MIN, 16'hf801);
		rd(CMD_SENSE_V, 16'h0456);
		wr(CMD_SENSE_V, 16'h0000);
		rd(CMD_SENSE_V, 16'h0456);
		wr(CMD_PAGE, 16'h0000);
		rd(CMD_VOUT_MIN, 16'h0000);
		rd(CMD_COMMON, 16'h005a);
	endtask : t_meas

	task automatic t_addr;
		wr(CMD_ALT_CMD, 16'h1234);
		wr(CMD_ALT_DATA0, 16'h5678);
		wr(CMD_ALT_DATA1, 16'h9abc);
		rd(CMD_ALT_CMD, 16'h1234);
		rd(CMD_ALT_DATA0, 16'h5678);
		rd(CMD_ALT_DATA1, 16'h9abc);
		selLo = 2'h2;
		selHi = 2'h2;
		busAddr = 7'h64;
		repeat (3) @(posedge clk);
		#1 check(20'(addrHit), 20'h00001);
		busAddr = 7'h63;
		#1 check(20'(addrHit), 20'h00000);
		wr(CMD_BASE_ADDR, 16'h0010);
		selHi = 2'h0;
		selLo = 2'h1;
		busAddr = 7'h11;
		repeat (3) @(posedge clk);
		#1 check(20'(addrHit), 20'h00001);
	endtask : t_addr

	task automatic report_and_stop;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	initial
	begin
		nrst = 1'b0;
		wpPin = 1'b0;
		flogLockSet = 1'b0;
		busAddr = 7'h00;
		selLo = 2'h0;
		selHi = 2'h0;
		commonStatus = 8'h5a;
		meas = '0;
		flogWr = '0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		t_reset();
		t_paging();
		t_global();
		t_protect();
		t_flog();
		t_meas();
		t_addr();
		report_and_stop();
	end
endmodule : testbench
